// *** tls_pkg.sv ***
// constants, encodings and carrier types of the travel limit supervisor
// assumes a single 10 MHz system clock and an AXI4-Lite register bus
`default_nettype none
package tls_pkg;
  localparam int          TLS_AXES          = 4;
  localparam int          TLS_ADDR_W        = 8;
  localparam int          TLS_IRQ_W         = 6;
  localparam int          TLS_CLK_HZ        = 10_000_000;
  // register byte offsets
  localparam logic [7:0]  TLS_OFF_CTRL      = 8'h00;
  localparam logic [7:0]  TLS_OFF_POLAR     = 8'h04;
  localparam logic [7:0]  TLS_OFF_STATUS    = 8'h08;
  localparam logic [7:0]  TLS_OFF_IRQ_STAT  = 8'h0C;
  localparam logic [7:0]  TLS_OFF_IRQ_MASK  = 8'h10;
  localparam logic [7:0]  TLS_OFF_ERRQ      = 8'h14;
  // control field positions
  localparam int          TLS_CTRL_SENSE    = 0;
  localparam int          TLS_CTRL_TERM     = 1;
  localparam int          TLS_CTRL_AUTO     = 3;
  localparam int          TLS_CTRL_SRST     = 4;
  // status field positions
  localparam int          TLS_ST_SENSE      = 0;
  localparam int          TLS_ST_FAULT      = 1;
  localparam int          TLS_ST_RUN        = 2;
  localparam int          TLS_ST_LEVEL      = 4;
  localparam int          TLS_ST_ACTIVE     = 12;
  // interrupt bits: 3..0 limit event per axis
  localparam int          TLS_IRQ_INIT      = 4;
  localparam int          TLS_IRQ_AUTO      = 5;
  // error queue fields
  localparam int          TLS_ERRQ_CNT      = 4;
  localparam logic [3:0]  TLS_ERR_NONE      = 4'h0;
  localparam logic [3:0]  TLS_ERR_INIT      = 4'h1;
  localparam logic [3:0]  TLS_ERR_AUTO      = 4'h2;
  localparam logic [3:0]  TLS_ERR_CNT_MAX   = 4'hF;
  // termination codes
  localparam logic [1:0]  TLS_TERM_PULL_UP  = 2'h0;
  localparam logic [1:0]  TLS_TERM_PULL_DN  = 2'h1;
  localparam logic [1:0]  TLS_TERM_NONE     = 2'h2;
  localparam logic [1:0]  TLS_TERM_DEFAULT  = 2'h3;
  // reset values
  localparam logic        TLS_RST_SENSE     = 1'b1;
  localparam logic [1:0]  TLS_RST_TERM      = TLS_TERM_PULL_UP;
  localparam logic [7:0]  TLS_RST_POLAR     = 8'h00;
  localparam logic [5:0]  TLS_RST_MASK      = 6'h00;
  localparam logic [31:0] TLS_RD_ZERO       = 32'h0000_0000;
  // sync depth plus one spare cycle before the power-on capture
  localparam logic [1:0]  TLS_SETTLE_CYCLES = 2'h3;
  localparam logic [1:0]  TLS_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  TLS_RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0]
  {
    TLS_INIT = 2'b00,
    TLS_RUN  = 2'b01
  } tls_top_st_t;

  typedef enum logic [1:0]
  {
    TLS_AX_IDLE = 2'b00,
    TLS_AX_BACK = 2'b01
  } tls_axis_st_t;

  // one bit per line: neg lines in the upper nibble
  typedef struct packed
  {
    logic [TLS_AXES-1:0] neg;
    logic [TLS_AXES-1:0] pos;
  } tls_lines_t;

  typedef struct packed
  {
    logic stop;
    logic trap;
    logic move;
    logic dir_pos;
    logic restore;
    logic hold;
  } tls_motion_t;
endpackage : tls_pkg
`default_nettype wire

// *** tls_switch_model.sv ***
// mechanical limit switches of four stages, two contacts per axis
// assumes the supervisor selects the line termination
`timescale 1ns/1ps
`default_nettype none
module tls_switch_model
  import tls_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       pull_up,
  input  wire logic       pull_down,
  input  wire tls_lines_t pressed,
  output var  tls_lines_t lines
);
  initial lines = '1;
  // an open contact without termination floats: toggle so no stale level is read
  always @(posedge aclk)
  begin
    for (int i = 0; i < 2 * TLS_AXES; i++)
    begin
      if (pressed[i])
        lines[i] <= pull_down; // closed contact pulls against the termination
      else
        lines[i] <= pull_up ? 1'b1 : (pull_down ? 1'b0 : ~lines[i]);
    end
  end
endmodule : tls_switch_model
`default_nettype wire

// *** tls_sync.sv ***
// two-stage synchroniser for the limit switch lines
// assumes inputs may change at any time relative to aclk
`timescale 1ns/1ps
`default_nettype none
module tls_sync
  import tls_pkg::*;
#(
  parameter int W = 8
)
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] q_out
);
  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tls_sync_st_t;

  tls_sync_st_t q;
  tls_sync_st_t d;

  always_comb
  begin
    d    = q;
    d.s1 = d_in;
    d.s2 = q.s1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= '0;
    else
      q <= d;
  end

  assign q_out = q.s2;

  a_sync_delay : assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(aresetn, 2) && $past(aresetn)) |-> q_out == $past(d_in, 2))
    else $error("sync output is not the input two cycles late");
endmodule : tls_sync
`default_nettype wire

// *** tls_travel_limit_supervisor.sv ***
// travel limit supervisor: four axes, two limit lines each, AXI4-Lite slave
// assumes limit lines are raw switch levels and motion commands go to a profiler
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tls_travel_limit_supervisor
  import tls_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [TLS_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output var  logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output var  logic                  s_axi_wready,
  output var  logic [1:0]            s_axi_bresp,
  output var  logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [TLS_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output var  logic                  s_axi_arready,
  output var  logic [31:0]           s_axi_rdata,
  output var  logic [1:0]            s_axi_rresp,
  output var  logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire tls_lines_t            limit_in,
  output var  logic                  term_pull_up,
  output var  logic                  term_pull_down,
  output var  tls_motion_t [TLS_AXES-1:0] motion_cmd,
  output var  logic                  irq
);
  typedef struct packed
  {
    tls_top_st_t                      top;
    logic [1:0]                       settle;
    logic                             aw_got;
    logic [TLS_ADDR_W-1:0]            aw_addr;
    logic                             w_got;
    logic [31:0]                      wdata;
    logic                             wlane0;
    logic                             awready;
    logic                             wready;
    logic                             bvalid;
    logic [1:0]                       bresp;
    logic                             arready;
    logic                             rvalid;
    logic [31:0]                      rdata;
    logic [1:0]                       rresp;
    logic                             sense_en;
    logic [1:0]                       term;
    tls_lines_t                       polar;
    tls_lines_t                       trip_prev;
    logic                             init_fault;
    logic [TLS_IRQ_W-1:0]             irq_stat;
    logic [TLS_IRQ_W-1:0]             irq_mask;
    logic [3:0]                       err_code;
    logic [3:0]                       err_cnt;
    tls_axis_st_t [TLS_AXES-1:0]      ax;
    logic [TLS_AXES-1:0]              ax_neg;
    tls_motion_t [TLS_AXES-1:0]       mot;
    logic                             pull_up;
    logic                             pull_dn;
    logic                             irq;
  } tls_state_t;

  tls_state_t q;
  tls_state_t d;
  tls_state_t keep;
  tls_lines_t lv;
  tls_lines_t tripped;
  tls_lines_t rise;
  logic       wr_fire;
  logic       wr_ctrl;
  logic       mismatch;

  function automatic logic tls_mapped(input logic [TLS_ADDR_W-1:0] a);
    tls_mapped = (a == TLS_OFF_CTRL) || (a == TLS_OFF_POLAR) || (a == TLS_OFF_STATUS)
              || (a == TLS_OFF_IRQ_STAT) || (a == TLS_OFF_IRQ_MASK) || (a == TLS_OFF_ERRQ);
  endfunction : tls_mapped

  function automatic tls_state_t tls_defaults();
    tls_state_t s;
    s          = '0;
    s.top      = TLS_INIT;
    s.sense_en = TLS_RST_SENSE;
    s.term     = TLS_RST_TERM;
    s.polar    = TLS_RST_POLAR;
    s.irq_mask = TLS_RST_MASK;
    s.err_code = TLS_ERR_NONE;
    s.pull_up  = 1'b1;
    s.awready  = 1'b1;
    s.wready   = 1'b1;
    s.arready  = 1'b1;
    for (int i = 0; i < TLS_AXES; i++)
      s.ax[i] = TLS_AX_IDLE;
    tls_defaults = s;
  endfunction : tls_defaults

  tls_sync #(.W(2 * TLS_AXES)) u_sync
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d_in    (limit_in),
    .q_out   (lv)
  );

  // tripped when the synced level equals the programmed tripped level
  assign tripped  = ~(lv ^ q.polar);
  assign rise     = (q.top == TLS_RUN) ? (tripped & ~q.trip_prev) : '0;
  assign mismatch = |(lv.pos ^ lv.neg);
  assign wr_fire  = q.aw_got && q.w_got && !q.bvalid;
  assign wr_ctrl  = wr_fire && q.wlane0 && (q.aw_addr == TLS_OFF_CTRL);

  always_comb
  begin
    keep = '0;
    d    = q;
    for (int i = 0; i < TLS_AXES; i++)
    begin
      d.mot[i].stop    = 1'b0;
      d.mot[i].restore = 1'b0;
    end
    // bus capture, address and data taken in either order
    if (s_axi_awvalid && q.awready)
    begin
      d.aw_got  = 1'b1;
      d.aw_addr = s_axi_awaddr & ~8'h03;
    end
    if (s_axi_wvalid && q.wready)
    begin
      d.w_got  = 1'b1;
      d.wdata  = s_axi_wdata;
      d.wlane0 = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;
    if (wr_fire)
    begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = tls_mapped(q.aw_addr) ? TLS_RESP_OKAY : TLS_RESP_SLVERR;
      if (q.wlane0)
      begin
        case (q.aw_addr)
          TLS_OFF_CTRL:
          begin
            d.sense_en = q.wdata[TLS_CTRL_SENSE];
            d.term     = q.wdata[TLS_CTRL_TERM +: 2];
          end
          TLS_OFF_POLAR:    d.polar    = q.wdata[7:0];
          TLS_OFF_IRQ_STAT: d.irq_stat = q.irq_stat & ~q.wdata[TLS_IRQ_W-1:0];
          TLS_OFF_IRQ_MASK: d.irq_mask = q.wdata[TLS_IRQ_W-1:0];
          default:          d.irq_mask = d.irq_mask;
        endcase
      end
    end
    if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;
    if (s_axi_arvalid && q.arready)
    begin
      d.rvalid = 1'b1;
      d.rresp  = tls_mapped(s_axi_araddr & ~8'h03) ? TLS_RESP_OKAY : TLS_RESP_SLVERR;
      d.rdata  = TLS_RD_ZERO;
      case (s_axi_araddr & ~8'h03)
        TLS_OFF_CTRL:
        begin
          d.rdata[TLS_CTRL_SENSE]   = q.sense_en;
          d.rdata[TLS_CTRL_TERM +: 2] = q.term;
        end
        TLS_OFF_POLAR:    d.rdata[7:0] = q.polar;
        TLS_OFF_STATUS:
        begin
          d.rdata[TLS_ST_SENSE] = q.sense_en;
          d.rdata[TLS_ST_FAULT] = q.init_fault;
          d.rdata[TLS_ST_RUN]   = (q.top == TLS_RUN);
          d.rdata[TLS_ST_LEVEL +: 8] = lv;
          for (int i = 0; i < TLS_AXES; i++)
            d.rdata[TLS_ST_ACTIVE + i] = (q.ax[i] == TLS_AX_BACK);
        end
        TLS_OFF_IRQ_STAT: d.rdata[TLS_IRQ_W-1:0] = q.irq_stat;
        TLS_OFF_IRQ_MASK: d.rdata[TLS_IRQ_W-1:0] = q.irq_mask;
        TLS_OFF_ERRQ:
        begin
          // reading drains the queue; a push in the same cycle survives
          d.rdata[3:0]              = q.err_code;
          d.rdata[TLS_ERRQ_CNT +: 4] = q.err_cnt;
          d.err_code                = TLS_ERR_NONE;
          d.err_cnt                 = 4'h0;
        end
        default:          d.rdata = TLS_RD_ZERO;
      endcase
    end
    // supervisor sequencing; events set after clears so they win
    case (q.top)
      TLS_INIT:
      begin
        if (q.settle != TLS_SETTLE_CYCLES)
          d.settle = q.settle + 2'h1;
        else
        begin
          d.polar     = ~lv;
          d.trip_prev = '0;
          d.top       = TLS_RUN;
          if (mismatch)
          begin
            d.sense_en               = 1'b0;
            d.init_fault             = 1'b1;
            d.irq_stat[TLS_IRQ_INIT] = 1'b1;
            d.err_code               = TLS_ERR_INIT;
            d.err_cnt                = (d.err_cnt == TLS_ERR_CNT_MAX) ? d.err_cnt
                                                                   : d.err_cnt + 4'h1;
          end
        end
      end
      TLS_RUN:
      begin
        d.trip_prev = tripped;
        for (int i = 0; i < TLS_AXES; i++)
          if (rise.pos[i] || rise.neg[i])
            d.irq_stat[i] = 1'b1;
        if (wr_ctrl && q.wdata[TLS_CTRL_AUTO])
        begin
          // polarity left untouched on purpose: only report
          d.irq_stat[TLS_IRQ_AUTO] = 1'b1;
          d.err_code               = TLS_ERR_AUTO;
          d.err_cnt                = (d.err_cnt == TLS_ERR_CNT_MAX) ? d.err_cnt
                                                                 : d.err_cnt + 4'h1;
        end
      end
      default: d.top = TLS_INIT;
    endcase
    // per-axis back-off; runs on to release even if sensing is switched off
    for (int i = 0; i < TLS_AXES; i++)
    begin
      case (q.ax[i])
        TLS_AX_IDLE:
        begin
          if (q.sense_en && (rise.pos[i] || rise.neg[i]))
          begin
            d.ax[i]          = TLS_AX_BACK;
            d.ax_neg[i]      = rise.neg[i];
            d.mot[i].stop    = 1'b1;
            d.mot[i].trap    = 1'b1;
            d.mot[i].move    = 1'b1;
            d.mot[i].dir_pos = rise.neg[i];
            d.mot[i].hold    = 1'b0;
          end
        end
        TLS_AX_BACK:
        begin
          if (q.ax_neg[i] ? !tripped.neg[i] : !tripped.pos[i])
          begin
            d.ax[i]          = TLS_AX_IDLE;
            d.mot[i].stop    = 1'b1;
            d.mot[i].move    = 1'b0;
            d.mot[i].trap    = 1'b0;
            d.mot[i].restore = 1'b1;
            d.mot[i].hold    = 1'b1;
          end
        end
        default: d.ax[i] = TLS_AX_IDLE;
      endcase
    end
    // software reset keeps only the bus handshake in flight
    if (wr_ctrl && q.wdata[TLS_CTRL_SRST])
    begin
      keep = d;
      d    = tls_defaults();
      d.aw_got  = keep.aw_got;
      d.aw_addr = keep.aw_addr;
      d.w_got   = keep.w_got;
      d.wdata   = keep.wdata;
      d.wlane0  = keep.wlane0;
      d.bvalid  = keep.bvalid;
      d.bresp   = keep.bresp;
      d.rvalid  = keep.rvalid;
      d.rdata   = keep.rdata;
      d.rresp   = keep.rresp;
    end
    d.pull_up = (d.term == TLS_TERM_PULL_UP) || (d.term == TLS_TERM_DEFAULT);
    d.pull_dn = (d.term == TLS_TERM_PULL_DN);
    d.irq     = |(d.irq_stat & d.irq_mask);
    d.awready = !d.aw_got && !d.bvalid;
    d.wready  = !d.w_got && !d.bvalid;
    d.arready = !d.rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= tls_defaults();
    else
      q <= d;
  end

  assign s_axi_awready  = q.awready;
  assign s_axi_wready   = q.wready;
  assign s_axi_bvalid   = q.bvalid;
  assign s_axi_bresp    = q.bresp;
  assign s_axi_arready  = q.arready;
  assign s_axi_rvalid   = q.rvalid;
  assign s_axi_rdata    = q.rdata;
  assign s_axi_rresp    = q.rresp;
  assign term_pull_up   = q.pull_up;
  assign term_pull_down = q.pull_dn;
  assign motion_cmd     = q.mot;
  assign irq            = q.irq;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_term_select : assert property (
    term_pull_up == (q.term != TLS_TERM_PULL_DN && q.term != TLS_TERM_NONE) && !(term_pull_up && term_pull_down))
    else $error("termination outputs disagree with selection");
  a_sense_reset : assert property ($past(!aresetn) |-> q.sense_en && term_pull_up)
    else $error("sensing or pull-up not set after reset");
  a_capture_fault : assert property (
    (q.top == TLS_INIT && q.settle == TLS_SETTLE_CYCLES && mismatch && !wr_ctrl)
    |=> !q.sense_en && q.init_fault && q.irq_stat[TLS_IRQ_INIT] && q.err_code == TLS_ERR_INIT)
    else $error("mismatched axis did not disable sensing");
  a_capture_polar : assert property (
    (q.top == TLS_INIT && q.settle == TLS_SETTLE_CYCLES && !wr_fire)
    |=> q.polar == ~$past(lv) && q.top == TLS_RUN)
    else $error("auto polarity not captured from levels");
  a_auto_runtime : assert property (
    (q.top == TLS_RUN && wr_ctrl && q.wdata[TLS_CTRL_AUTO] && !q.wdata[TLS_CTRL_SRST])
    |=> q.irq_stat[TLS_IRQ_AUTO] && $stable(q.polar) && q.top == TLS_RUN)
    else $error("runtime auto request changed limit handling");
  a_event_set : assert property (
    (|rise && !wr_ctrl) |=> ((q.irq_stat[3:0] & $past(rise.pos | rise.neg)) == $past(rise.pos | rise.neg)))
    else $error("limit change did not raise axis event");
  a_backoff_start : assert property (
    (q.ax[0] == TLS_AX_IDLE && q.sense_en && rise.pos[0] && !wr_ctrl)
    |=> motion_cmd[0].stop && motion_cmd[0].move && !motion_cmd[0].dir_pos ##1 !motion_cmd[0].stop)
    else $error("trip did not start back-off");
  a_release_restore : assert property (
    (q.ax[0] == TLS_AX_BACK && !(q.ax_neg[0] ? tripped.neg[0] : tripped.pos[0]) && !wr_ctrl)
    |=> motion_cmd[0].restore && motion_cmd[0].hold && !motion_cmd[0].move && !motion_cmd[0].trap)
    else $error("release did not restore and hold");
  a_soft_reset : assert property (
    (wr_ctrl && q.wdata[TLS_CTRL_SRST])
    |=> q.top == TLS_INIT && q.sense_en && q.term == TLS_TERM_PULL_UP && q.irq_stat == '0 ##4 q.top == TLS_RUN)
    else $error("software reset did not restore defaults");
  a_irq_level : assert property (irq == |(q.irq_stat & q.irq_mask))
    else $error("interrupt output disagrees with status and mask");
  a_resp_hold : assert property ((s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

  c_init_fault : cover property (q.top == TLS_INIT ##1 q.init_fault);
  c_backoff    : cover property (q.ax[0] == TLS_AX_BACK ##[1:50] motion_cmd[0].restore);
  c_auto_err   : cover property (q.top == TLS_RUN && wr_ctrl && q.wdata[TLS_CTRL_AUTO]);
  c_irq        : cover property ($rose(irq) ##[1:50] $fell(irq));
endmodule : tls_travel_limit_supervisor
`default_nettype wire

// *** tls_travel_limit_supervisor_test.sv ***
// self-checking bench for the travel limit supervisor
// assumes the switch model on the limit lines; this bench is the bus master
`timescale 1ns/1ps
`default_nettype none
module tls_travel_limit_supervisor_test
  import tls_pkg::*;
();
  localparam logic [1:0] OK = TLS_RESP_OKAY;
  localparam logic [1:0] ER = TLS_RESP_SLVERR;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pu, pd, irq;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  logic [15:0] seed = 16'hC354;
  tls_lines_t pressed = '0, lines;
  tls_motion_t [TLS_AXES-1:0] motion;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int bad_count = 0, samples_checked = 0;

  always #50 aclk = ~aclk;

  tls_travel_limit_supervisor tls_travel_limit_supervisor_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .limit_in(lines), .term_pull_up(pu), .term_pull_down(pd), .motion_cmd(motion), .irq(irq));

  tls_switch_model tls_switch_model_i (.aclk(aclk), .pull_up(pu), .pull_down(pd),
    .pressed(pressed), .lines(lines));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tmo();
    bad_count++;
    report_and_stop();
  endtask : tmo

  // responses are judged here, against the oldest note of the driver
  always @(posedge aclk)
  begin
    if (rvalid && rready)
      chk("read response", rq.pop_front(), {rresp, rdata});
    if (bvalid && bready)
      chk("write response", {32'h0, bq.pop_front()}, {32'h0, bresp});
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (!bvalid && n < 40);
    bready <= 1'b0;
    if (n >= 40)
      tmo();
    // one idle edge: the next call must not raise bready in this time step
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
    int n;
    n = 0;
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (!rvalid && n < 40);
    rready <= 1'b0;
    if (n >= 40)
      tmo();
    // one idle edge: the next call must not raise rready in this time step
    @(posedge aclk);
  endtask : rd

  // the stop pulse stands one cycle: sample it in that cycle
  task automatic wait_stop(input int ax, input logic [5:0] exp, input logic [5:0] m);
    int n;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end while (!motion[ax].stop && n < 20);
    if (n >= 20)
      tmo();
    chk("motion command", {28'h0, exp}, {28'h0, motion[ax] & m});
  endtask : wait_stop

  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(TLS_OFF_STATUS, OK, 32'h0000_0FF5);
    rd(TLS_OFF_POLAR, OK, 32'h0000_0000);
    rd(TLS_OFF_CTRL, OK, 32'h0000_0001);
    chk("pull-up select", 34'h1, {33'h0, pu});
    rd(8'h18, ER, 32'h0000_0000);
    wr(8'h1C, 32'h0000_0001, ER);
    // sensing off here: floating lines must not start back-off moves
    for (int k = 0; k < 4; k++)
    begin
      wr(TLS_OFF_CTRL, {29'h0, k[1:0], 1'b0}, OK);
      rd(TLS_OFF_CTRL, OK, {29'h0, k[1:0], 1'b0});
      chk("termination", {32'h0, k == 0 || k == 3, k == 1}, {32'h0, pu, pd});
    end
    wr(TLS_OFF_CTRL, 32'h0000_0000, OK);
    repeat (4) @(posedge aclk);
    wr(TLS_OFF_IRQ_STAT, 32'h0000_003F, OK);
    seed = lfsr(seed);
    wr(TLS_OFF_POLAR, {24'h0, seed[7:0]}, OK);
    rd(TLS_OFF_POLAR, OK, {24'h0, seed[7:0]});
    rd(TLS_OFF_IRQ_STAT, OK, {28'h0, seed[3:0] | seed[7:4]});
    rd(TLS_OFF_STATUS, OK, 32'h0000_0FF4);
    wr(TLS_OFF_POLAR, 32'h0000_0000, OK);
    wr(TLS_OFF_IRQ_STAT, 32'h0000_003F, OK);
    wr(TLS_OFF_CTRL, 32'h0000_0001, OK);
    wr(TLS_OFF_IRQ_MASK, 32'h0000_000F, OK);
    rd(TLS_OFF_IRQ_MASK, OK, 32'h0000_000F);
    // byte lane 0 off: the write is answered but must change nothing
    wstrb <= 4'h0;
    wr(TLS_OFF_IRQ_MASK, 32'h0000_0000, OK);
    wstrb <= 4'hF;
    rd(TLS_OFF_IRQ_MASK, OK, 32'h0000_000F);
    pressed.pos[0] <= 1'b1;
    wait_stop(0, 6'b111000, 6'b111111);
    @(posedge aclk);
    chk("irq", 34'h1, {33'h0, irq});
    rd(TLS_OFF_STATUS, OK, 32'h0000_1FE5);
    pressed.pos[0] <= 1'b0;
    wait_stop(0, 6'b100011, 6'b111011);
    wr(TLS_OFF_IRQ_STAT, 32'h0000_0001, OK);
    chk("irq", 34'h0, {33'h0, irq});
    rd(TLS_OFF_IRQ_STAT, OK, 32'h0000_0000);
    pressed.neg[2] <= 1'b1;
    wait_stop(2, 6'b111100, 6'b111111);
    pressed.neg[2] <= 1'b0;
    wait_stop(2, 6'b100011, 6'b111011);
    wr(TLS_OFF_CTRL, 32'h0000_0009, OK);
    rd(TLS_OFF_IRQ_STAT, OK, 32'h0000_0024);
    rd(TLS_OFF_ERRQ, OK, 32'h0000_0012);
    rd(TLS_OFF_POLAR, OK, 32'h0000_0000);
    rd(TLS_OFF_STATUS, OK, 32'h0000_0FF5);
    // a stage parked on its switch during the restart
    pressed.pos[1] <= 1'b1;
    repeat (6) @(posedge aclk);
    wr(TLS_OFF_CTRL, 32'h0000_0010, OK);
    repeat (6) @(posedge aclk);
    rd(TLS_OFF_STATUS, OK, 32'h0000_0FD6);
    rd(TLS_OFF_ERRQ, OK, 32'h0000_0011);
    rd(TLS_OFF_POLAR, OK, 32'h0000_0002);
    rd(TLS_OFF_IRQ_MASK, OK, 32'h0000_0000);
    pressed.pos[1] <= 1'b0;
    repeat (6) @(posedge aclk);
    rd(TLS_OFF_STATUS, OK, 32'h0000_0FF6);
    rd(TLS_OFF_IRQ_STAT, OK, 32'h0000_0012);
    report_and_stop();
  end
endmodule : tls_travel_limit_supervisor_test
`default_nettype wire
